/* File: include/mtc_defs.vh */
`ifndef MTC_DEFS_VH
`define MTC_DEFS_VH

// Register indices; byte address is four times the index
`define MTC_IDX_CTRL_CH4      8'h53
`define MTC_IDX_CTRL_CH5      8'h54
`define MTC_IDX_CTRL_CH6      8'h55
`define MTC_IDX_CODE_CH4      8'h5B
`define MTC_IDX_CODE_CH5      8'h5C
`define MTC_IDX_UPPER_CH4     8'h63
`define MTC_IDX_UPPER_CH5     8'h64
`define MTC_IDX_LOWER_CH4     8'h6B
`define MTC_IDX_LOWER_CH5     8'h6C
`define MTC_IDX_STATUS        8'h70
`define MTC_IDX_APPLIED_CH4   8'h71
`define MTC_IDX_APPLIED_CH5   8'h72

// Control register fields
`define MTC_CTRL_EN_BIT       2
`define MTC_CTRL_SEL_MSB      1
`define MTC_CTRL_SEL_LSB      0
`define MTC_CTRL_WIDTH        3

// Midpoint select encodings
`define MTC_MID_1V25          2'h0
`define MTC_MID_1V00          2'h1
`define MTC_MID_0V80          2'h2
`define MTC_MID_0V60          2'h3

// Status register fields, per channel nibble
`define MTC_ST_ACTIVE_BIT     0
`define MTC_ST_CLAMP_BIT      1
`define MTC_ST_FAULT_BIT      2
`define MTC_ST_NIBBLE         4

// Reset values
`define MTC_RST_CTRL          3'h0
`define MTC_RST_CODE          8'h7F
`define MTC_RST_UPPER         8'hFF
`define MTC_RST_LOWER         8'h00

// Bus constants
`define MTC_HRESP_OKAY        1'b0
`define MTC_IDX_NONE          8'h00

`endif

/* File: rtl/mtc_trim_chan.v */
`timescale 1ns/1ps
`include "mtc_defs.vh"
module mtc_trim_chan #(
  parameter CODE_W = 8
) (
  // Clock and reset
  input  wire              hclk,
  input  wire              hresetn,
  // Channel settings
  input  wire              enable,
  input  wire [CODE_W-1:0] code,
  input  wire [CODE_W-1:0] upper,
  input  wire [CODE_W-1:0] lower,
  // Applied output
  output reg  [CODE_W-1:0] eff_code,
  output reg               active,
  output reg               clamped,
  output reg               fault
);

  reg  [CODE_W-1:0] next_eff_code;
  wire              limit_bad;
  wire              over;
  wire              under;

  assign limit_bad = (lower > upper);
  assign over      = (code > upper);
  assign under     = (code < lower);

  always @* begin
    next_eff_code = code;
    // R04 upper clamp
    if (over) begin
      next_eff_code = upper;
    // R05 lower clamp
    end else if (under) begin
      next_eff_code = lower;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eff_code <= `MTC_RST_CODE;
      active   <= 1'b0;
      clamped  <= 1'b0;
      fault    <= 1'b0;
    end else begin
      eff_code <= next_eff_code;
      // R01 enable gate, R06 inverted limits disable
      active   <= enable & ~limit_bad;
      clamped  <= over | under;
      fault    <= limit_bad;
    end
  end

endmodule // mtc_trim_chan

/* File: rtl/mtc_ahb_if.v */
`timescale 1ns/1ps
`include "mtc_defs.vh"
module mtc_ahb_if (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg  [31:0] hrdata,
  output reg         hresp,
  // Register side
  output wire        wr_en,
  output wire [7:0]  wr_data,
  output wire [7:0]  reg_idx,
  input  wire [7:0]  rd_data
);

  localparam ST_IDLE  = 3'b001;
  localparam ST_WRITE = 3'b010;
  localparam ST_READ  = 3'b100;

  reg  [2:0] state;
  reg  [7:0] idx;
  wire       accept;
  wire       aligned;

  // Only whole words are served, so hsize is not examined
  assign accept  = hsel & htrans[1] & hready;
  assign aligned = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'h0);
  assign wr_en   = (state == ST_WRITE);
  assign wr_data = hwdata[7:0];
  assign reg_idx = idx;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= ST_IDLE;
      idx       <= `MTC_IDX_NONE;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= `MTC_HRESP_OKAY;
    end else begin
      hresp <= `MTC_HRESP_OKAY;
      case (state)
        ST_IDLE, ST_WRITE: begin
          if (accept) begin
            // Misaligned or out-of-range lands on an unused index
            idx       <= aligned ? haddr[9:2] : `MTC_IDX_NONE;
            state     <= hwrite ? ST_WRITE : ST_READ;
            hreadyout <= hwrite;
          end else begin
            state <= ST_IDLE;
          end
        end
        ST_READ: begin
          // One wait state so a read sees a write just completed
          hrdata    <= {24'h00_0000, rd_data};
          hreadyout <= 1'b1;
          state     <= ST_IDLE;
        end
        default: begin
          state     <= ST_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

endmodule // mtc_ahb_if

/* File: rtl/mtc_top.v */
// Overview of operation
// R01: Control bit 2 enables the channel output; inactive while clear.
// R02: Control bits 1:0 pick midpoint voltage 1.25, 1.0, 0.8 or 0.6 V.
// R03: Each channel has a read/write 8-bit code; 0x7F is the midpoint. Only channels 4 and 5 have a code register here.
// R04: A code above the upper limit applies the upper limit instead.
// R05: A code below the lower limit applies the lower limit instead.
// R06: Lower limit above upper limit holds the channel output disabled.
// R07: Control bits 7:3 ignore writes and read back as zero.
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ps
`include "mtc_defs.vh"
module mtc_top #(
  parameter CODE_W = 8
) (
  // Clock and reset
  input  wire              hclk,
  input  wire              hresetn,
  // AHB-Lite slave
  input  wire              hsel,
  input  wire [31:0]       haddr,
  input  wire [1:0]        htrans,
  input  wire              hwrite,
  input  wire [2:0]        hsize,
  input  wire [31:0]       hwdata,
  input  wire              hready,
  output wire              hreadyout,
  output wire [31:0]       hrdata,
  output wire              hresp,
  // Channel 4 trim output
  output wire [CODE_W-1:0] ch4_trim_code,
  output wire              ch4_trim_output_enable,
  output wire [1:0]        ch4_midpoint_select,
  // Channel 5 trim output
  output wire [CODE_W-1:0] ch5_trim_code,
  output wire              ch5_trim_output_enable,
  output wire [1:0]        ch5_midpoint_select,
  // Channel 6 control only
  output wire              ch6_trim_output_enable,
  output wire [1:0]        ch6_midpoint_select
);

  localparam NCH = 2;

  // Register storage, index 0 is channel 4
  reg  [`MTC_CTRL_WIDTH-1:0] trim_ctrl [0:NCH];
  reg  [CODE_W-1:0]          trim_code_bits [0:NCH-1];
  reg  [CODE_W-1:0]          upper_limit [0:NCH-1];
  reg  [CODE_W-1:0]          lower_limit [0:NCH-1];

  wire [CODE_W-1:0]          eff_code [0:NCH-1];
  wire [NCH-1:0]             ch_active;
  wire [NCH-1:0]             ch_clamped;
  wire [NCH-1:0]             ch_fault;

  wire                       wr_en;
  wire [7:0]                 wr_data;
  wire [7:0]                 reg_idx;
  reg  [7:0]                 rd_data;
  integer                    k;

  mtc_ahb_if u_bus (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .wr_en     (wr_en),
    .wr_data   (wr_data),
    .reg_idx   (reg_idx),
    .rd_data   (rd_data)
  );

  // Register writes; unmapped indices are dropped silently
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (k = 0; k <= NCH; k = k + 1) begin
        trim_ctrl[k] <= `MTC_RST_CTRL;
      end
      for (k = 0; k < NCH; k = k + 1) begin
        trim_code_bits[k] <= `MTC_RST_CODE;
        upper_limit[k]    <= `MTC_RST_UPPER;
        lower_limit[k]    <= `MTC_RST_LOWER;
      end
    end else if (wr_en) begin
      case (reg_idx)
        // R07 drop upper bits
        `MTC_IDX_CTRL_CH4:  trim_ctrl[0] <= wr_data[`MTC_CTRL_WIDTH-1:0];
        `MTC_IDX_CTRL_CH5:  trim_ctrl[1] <= wr_data[`MTC_CTRL_WIDTH-1:0];
        `MTC_IDX_CTRL_CH6:  trim_ctrl[2] <= wr_data[`MTC_CTRL_WIDTH-1:0];
        // R03 code registers, then the upper and lower limit registers
        `MTC_IDX_CODE_CH4:  trim_code_bits[0] <= wr_data;
        `MTC_IDX_CODE_CH5:  trim_code_bits[1] <= wr_data;
        `MTC_IDX_UPPER_CH4: upper_limit[0] <= wr_data;
        `MTC_IDX_UPPER_CH5: upper_limit[1] <= wr_data;
        `MTC_IDX_LOWER_CH4: lower_limit[0] <= wr_data;
        `MTC_IDX_LOWER_CH5: lower_limit[1] <= wr_data;
        default: begin
        end
      endcase
    end
  end

  // Read mux; unmapped and reserved bits read zero
  always @* begin
    rd_data = 8'h00;
    case (reg_idx)
      // R07 zero upper bits
      `MTC_IDX_CTRL_CH4:    rd_data = {5'h00, trim_ctrl[0]};
      `MTC_IDX_CTRL_CH5:    rd_data = {5'h00, trim_ctrl[1]};
      `MTC_IDX_CTRL_CH6:    rd_data = {5'h00, trim_ctrl[2]};
      `MTC_IDX_CODE_CH4:    rd_data = trim_code_bits[0];
      `MTC_IDX_CODE_CH5:    rd_data = trim_code_bits[1];
      `MTC_IDX_UPPER_CH4:   rd_data = upper_limit[0];
      `MTC_IDX_UPPER_CH5:   rd_data = upper_limit[1];
      `MTC_IDX_LOWER_CH4:   rd_data = lower_limit[0];
      `MTC_IDX_LOWER_CH5:   rd_data = lower_limit[1];
      `MTC_IDX_STATUS:      rd_data = {1'b0, ch_fault[1], ch_clamped[1], ch_active[1],
                                       1'b0, ch_fault[0], ch_clamped[0], ch_active[0]};
      `MTC_IDX_APPLIED_CH4: rd_data = eff_code[0];
      `MTC_IDX_APPLIED_CH5: rd_data = eff_code[1];
      default:              rd_data = 8'h00;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_chan
      mtc_trim_chan #(
        .CODE_W (CODE_W)
      ) u_chan (
        .hclk     (hclk),
        .hresetn  (hresetn),
        // R01 enable bit
        .enable   (trim_ctrl[g][`MTC_CTRL_EN_BIT]),
        .code     (trim_code_bits[g]),
        .upper    (upper_limit[g]),
        .lower    (lower_limit[g]),
        .eff_code (eff_code[g]),
        .active   (ch_active[g]),
        .clamped  (ch_clamped[g]),
        .fault    (ch_fault[g])
      );
    end
  endgenerate

  assign ch4_trim_code          = eff_code[0];
  assign ch4_trim_output_enable = ch_active[0];
  // R02 midpoint select
  assign ch4_midpoint_select    = trim_ctrl[0][`MTC_CTRL_SEL_MSB:`MTC_CTRL_SEL_LSB];
  assign ch5_trim_code          = eff_code[1];
  assign ch5_trim_output_enable = ch_active[1];
  assign ch5_midpoint_select    = trim_ctrl[1][`MTC_CTRL_SEL_MSB:`MTC_CTRL_SEL_LSB];
  // Channel 6 limits live elsewhere, so only its enable and midpoint select are passed on
  assign ch6_trim_output_enable = trim_ctrl[2][`MTC_CTRL_EN_BIT];
  assign ch6_midpoint_select    = trim_ctrl[2][`MTC_CTRL_SEL_MSB:`MTC_CTRL_SEL_LSB];

endmodule // mtc_top

/* File: sim/mtc_properties.sv */
`timescale 1ns/1ps
`include "mtc_defs.vh"
module mtc_checker #(
  parameter CODE_W = 8
) (
  // Bus
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic              hreadyout,
  input wire logic [31:0]       hrdata,
  // Channels
  input wire logic [CODE_W-1:0] ch4_trim_code,
  input wire logic              ch4_trim_output_enable,
  input wire logic [1:0]        ch5_midpoint_select,
  input wire logic              ch6_trim_output_enable
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_req(w);
    hsel && htrans[1] && hready && hwrite == w;
  endsequence
  sequence s_take(w, a);
    s_req(w) ##0 haddr == {22'h0, a, 2'b00};
  endsequence
  sequence s_read_done;
    !hreadyout ##1 hreadyout;
  endsequence
  AST_WR_NOWAIT: assert property (s_req(1'b1) |=> hreadyout)
    else $error("write data phase stalled");
  AST_RD_WAIT: assert property (s_req(1'b0) |=> s_read_done)
    else $error("read wait state wrong");
  AST_RD_UPPER: assert property (s_req(1'b0) ##1 s_read_done |-> hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  AST_CTRL_RSV: assert property (s_take(1'b0, `MTC_IDX_CTRL_CH4) ##1 s_read_done |-> hrdata[7:3] == 5'h0)
    else $error("control spare bits read nonzero");
  AST_EN_OFF: assert property (s_take(1'b1, `MTC_IDX_CTRL_CH4) ##1 !hwdata[2] |-> ##2 !ch4_trim_output_enable)
    else $error("channel 4 active with enable clear");
  AST_SEL: assert property (s_take(1'b1, `MTC_IDX_CTRL_CH5) ##1 1'b1 |=> ch5_midpoint_select == $past(hwdata[1:0]))
    else $error("channel 5 midpoint select wrong");
  AST_EN6: assert property (s_take(1'b1, `MTC_IDX_CTRL_CH6) ##1 1'b1 |=> ch6_trim_output_enable == $past(hwdata[2]))
    else $error("channel 6 enable wrong");
  AST_RST_CODE: assert property ($rose(hresetn) |-> ch4_trim_code == `MTC_RST_CODE && !ch4_trim_output_enable)
    else $error("channel 4 not at midpoint after reset");
endmodule // mtc_checker

/* File: sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire         hready;
  wire         hreadyout;
  wire  [31:0] hrdata;
  wire         hresp;
  wire  [7:0]  ch4_trim_code;
  wire         ch4_trim_output_enable;
  wire  [1:0]  ch4_midpoint_select;
  wire  [7:0]  ch5_trim_code;
  wire         ch5_trim_output_enable;
  wire  [1:0]  ch5_midpoint_select;
  wire         ch6_trim_output_enable;
  wire  [1:0]  ch6_midpoint_select;
  int          n_fail;
  int          checked;
  logic [7:0]  ridx [9] = '{8'h53, 8'h54, 8'h55, 8'h5B, 8'h5C, 8'h63, 8'h64, 8'h6B, 8'h6C};
  logic [7:0]  rval [9] = '{8'h00, 8'h00, 8'h00, 8'h7F, 8'h7F, 8'hFF, 8'hFF, 8'h00, 8'h00};
  logic [7:0]  mask [9] = '{8'h07, 8'h07, 8'h07, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0]  cin [5]  = '{8'h10, 8'h40, 8'h7F, 8'hC0, 8'hF0};
  logic [7:0]  cexp [5] = '{8'h40, 8'h40, 8'h7F, 8'hC0, 8'hC0};

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  mtc_top #(.CODE_W(8)) u_mtc_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .ch4_trim_code(ch4_trim_code), .ch4_trim_output_enable(ch4_trim_output_enable),
    .ch4_midpoint_select(ch4_midpoint_select), .ch5_trim_code(ch5_trim_code),
    .ch5_trim_output_enable(ch5_trim_output_enable), .ch5_midpoint_select(ch5_midpoint_select),
    .ch6_trim_output_enable(ch6_trim_output_enable), .ch6_midpoint_select(ch6_midpoint_select)
  );

  task give_verdict;
    $display("Checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask

  // Ready sampled at the falling edge, where it is settled
  task wait_rdy(output logic [31:0] d);
    logic r;
    int   n;
    n = 0;
    do begin
      @(negedge hclk);
      r = hreadyout;
      d = hrdata;
      @(posedge hclk);
      n++;
    end while (r !== 1'b1 && n < 50);
    if (r !== 1'b1) begin
      n_fail++;
      give_verdict;
    end
  endtask

  task xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {22'h0, idx, 2'b00};
    wait_rdy(d);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_rdy(d);
    chk({7'h0, hresp}, 8'h00);
  endtask

  task wr(input logic [7:0] idx, input logic [7:0] v);
    logic [31:0] d;
    xfer(1'b1, idx, v, d);
  endtask

  task rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    xfer(1'b0, idx, 8'h00, d);
    chk(d[7:0], exp);
  endtask

  // Applied code and enable lag the register write by one cycle
  task out_chk(input logic [7:0] ch, input logic [7:0] code, input logic en);
    repeat (2) @(negedge hclk);
    chk(ch[0] ? ch5_trim_code : ch4_trim_code, code);
    chk({7'h0, ch[0] ? ch5_trim_output_enable : ch4_trim_output_enable}, {7'h0, en});
    @(posedge hclk);
  endtask

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  initial begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hsize   = 3'h2;
    hwdata  = 32'h0;
    n_fail  = 0;
    checked = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    out_chk(8'h00, 8'h7F, 1'b0);
    for (int i = 0; i < 9; i++) begin
      rd_chk(ridx[i], rval[i]);
      wr(ridx[i], 8'hFA);
      rd_chk(ridx[i], 8'hFA & mask[i]);
    end
    // Unmapped index swallows writes
    wr(8'h00, 8'h5A);
    rd_chk(8'h00, 8'h00);
    for (logic [7:0] s = 8'h00; s < 8'h04; s++) begin
      for (logic [7:0] c = 8'h00; c < 8'h03; c++)
        wr(8'h53 + c, 8'hFC | s);
      @(negedge hclk);
      chk({6'h0, ch4_midpoint_select}, s);
      chk({6'h0, ch5_midpoint_select}, s);
      chk({6'h0, ch6_midpoint_select}, s);
      chk({7'h0, ch6_trim_output_enable}, 8'h01);
      @(posedge hclk);
    end
    for (logic [7:0] ch = 8'h00; ch < 8'h02; ch++) begin
      wr(8'h63 + ch, 8'hC0);
      wr(8'h6B + ch, 8'h40);
      for (int k = 0; k < 5; k++) begin
        wr(8'h5B + ch, cin[k]);
        out_chk(ch, cexp[k], 1'b1);
        rd_chk(8'h5B + ch, cin[k]);
      end
      wr(8'h6B + ch, 8'hC1);
      out_chk(ch, 8'hC0, 1'b0);
      rd_chk(8'h70, ch[0] ? 8'h62 : 8'h16);
      wr(8'h6B + ch, 8'hC0);
      out_chk(ch, 8'hC0, 1'b1);
      wr(8'h53 + ch, 8'h03);
      out_chk(ch, 8'hC0, 1'b0);
      rd_chk(8'h71 + ch, 8'hC0);
    end
    give_verdict;
  end
endmodule // testbench

bind mtc_top mtc_checker #(.CODE_W(CODE_W)) u_mtc_checker (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .ch4_trim_code(ch4_trim_code),
  .ch4_trim_output_enable(ch4_trim_output_enable), .ch5_midpoint_select(ch5_midpoint_select),
  .ch6_trim_output_enable(ch6_trim_output_enable)
);
